//--- inc/pls_pkg.sv
// constants for the link and slot status register block of one switch port
// assumes a 32-bit configuration access path with byte enables
package pls_pkg;

  // ==========================================================
  // register byte addresses
  localparam logic [7:0]  LINK_STATE_OFS   = 8'hd0;
  localparam logic [7:0]  SLOT_FEATURE_OFS = 8'hd4;

  // ==========================================================
  // link state report field positions (dword at LINK_STATE_OFS)
  localparam int          SPEED_LSB        = 16;
  localparam int          SPEED_W          = 4;
  localparam int          WIDTH_LSB        = 20;
  localparam int          WIDTH_W          = 6;
  localparam int          TRAIN_ERR_BIT    = 26;
  localparam int          TRAINING_BIT     = 27;
  localparam int          SLOT_CLK_BIT     = 28;
  localparam int          DL_ACTIVE_BIT    = 29;

  // link state reset values and codes
  localparam logic [3:0]  SPEED_2G5        = 4'h1;
  localparam logic [3:0]  SPEED_5G         = 4'h2;
  localparam logic [3:0]  SPEED_RST        = SPEED_5G;
  localparam logic [5:0]  WIDTH_RST_UP     = 6'h02;
  localparam logic [5:0]  WIDTH_RST_DN     = 6'h01;

  // ==========================================================
  // slot feature report field positions (dword at SLOT_FEATURE_OFS)
  localparam int          ATTN_BTN_BIT     = 0;
  localparam int          PWR_CTL_BIT      = 1;
  localparam int          ATTN_IND_BIT     = 3;
  localparam int          PWR_IND_BIT      = 4;
  localparam int          SURPRISE_BIT     = 5;
  localparam int          HP_CAPABLE_BIT   = 6;
  localparam int          PWR_VAL_LSB      = 7;
  localparam int          PWR_VAL_W        = 8;
  localparam int          PWR_SCALE_LSB    = 15;
  localparam int          PWR_SCALE_W      = 2;
  localparam int          SLOT_NUM_LSB     = 19;
  localparam int          SLOT_NUM_W       = 13;

  // implemented bits, writable bits and reset value of the slot dword, implemented bits of the link dword, a zero word
  localparam logic [31:0] SLOT_IMPL_MASK   = 32'hfff9fffb;
  localparam logic [31:0] SLOT_RW_MASK     = 32'h0001ff80;
  localparam logic [31:0] SLOT_RST         = 32'h00000000;
  localparam logic [31:0] LINK_IMPL_MASK   = 32'h3fff0000;
  localparam logic [31:0] ZERO_WORD        = 32'h00000000;

endpackage : pls_pkg

//--- src/pls_regs.sv
// link state and slot feature report registers of one switch port
// assumes status inputs are synchronous to ref_clk and a one-cycle
// configuration read or write strobe from the configuration logic
`timescale 1ns/1ps

// How it works
// RULE1 - the speed field shows the negotiated rate, 1 for 2.5 Gb/s and 2 for 5 Gb/s, reset to 2.
// RULE2 - the width field shows the trained lane count, reset to x2 upstream and x1 downstream.
// RULE3 - bit 26 is set on a training failure, cleared on entering L0, and resets to zero.
// RULE4 - bit 27 is high while training runs, cleared when it ends, and resets to zero.
// RULE5 - bit 28 shows the common reference clock choice, taken from the strap and overridable.
// RULE6 - bit 29 is one only while the data link state machine is active, reset to zero.
// RULE7 - the slot feature dword exists only on downstream ports and reads zero upstream.
// RULE8 - bits 0, 1, 3 and 4 advertise the slot button and indicators and power controller.
// RULE9 - bit 5 advertises surprise removal and bit 6 hot-plug capability, both reset to zero.
// RULE10 - bits 14:7 hold the writable power limit value, reset 0, a write sends a limit message.
// RULE11 - bits 16:15 hold the writable power limit scale, reset 0, a write sends a limit message.
// RULE12 - bits 31:19 report the physical slot number, reset to zero.
// RULE13 - the slot feature defaults can be replaced after reset by a management load strobe.
// RULE14 - reserved bits read zero and writes to them change nothing.
module pls_regs #(
  parameter bit IS_UPSTREAM = 1'b0                          // port faces the root
) (
  input  wire logic                          ref_clk,          // core clock
  input  wire logic                          rst,              // sync reset, high
  input  wire logic                          cfg_rd,           // config read strobe
  input  wire logic                          cfg_wr,           // config write strobe
  input  wire logic [7:0]                    cfg_addr,         // dword byte address
  input  wire logic [3:0]                    cfg_be,           // byte enables
  input  wire logic [31:0]                   cfg_wdata,        // write data
  output logic      [31:0]                   cfg_rdata,        // read data
  output logic                               cfg_rvalid,       // read answer pulse
  input  wire logic [pls_pkg::SPEED_W-1:0]   neg_speed,        // negotiated rate code
  input  wire logic [pls_pkg::WIDTH_W-1:0]   neg_width,        // negotiated lane count
  input  wire logic                          train_fail,       // training failed pulse
  input  wire logic                          train_active,     // training in progress
  input  wire logic                          l0_entered,       // reached L0 pulse
  input  wire logic                          dl_active,        // data link active state
  input  wire logic                          slot_clock_strap, // reference clock strap
  input  wire logic                          dflt_load,        // management load strobe
  input  wire logic [31:0]                   dflt_slot,        // slot feature defaults
  input  wire logic                          dflt_slot_clk,    // slot clock default
  output logic                               spl_msg_req,      // send limit message pulse
  output logic [pls_pkg::PWR_VAL_W-1:0]      spl_value,        // power limit value
  output logic [pls_pkg::PWR_SCALE_W-1:0]    spl_scale         // power limit scale
);
  import pls_pkg::*;

  localparam logic [5:0] WIDTH_RST = IS_UPSTREAM ? WIDTH_RST_UP : WIDTH_RST_DN;

  // ==========================================================
  // link state report
  logic [SPEED_W-1:0] speed_r;
  logic [WIDTH_W-1:0] width_r;
  logic               train_err_r;
  logic               training_r;
  logic               slot_clk_r;
  logic               dl_act_r;

  // speed and width captured when the link reaches L0
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      speed_r <= SPEED_RST;                                     // [RULE1]
      width_r <= WIDTH_RST;                                     // [RULE2]
    end
    else if (l0_entered)
    begin
      speed_r <= neg_speed;                                     // [RULE1]
      width_r <= neg_width;                                     // [RULE2]
    end
  end

  // training error, a failure in the same cycle as L0 wins
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      train_err_r <= 1'b0;
    else if (train_fail)
      train_err_r <= 1'b1;                                      // [RULE3]
    else if (l0_entered)
      train_err_r <= 1'b0;                                      // [RULE3]
  end

  // training indicator and data link active follow their sources
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      training_r <= 1'b0;
      dl_act_r   <= 1'b0;
    end
    else
    begin
      training_r <= train_active;                               // [RULE4]
      dl_act_r   <= dl_active;                                  // [RULE6]
    end
  end

  // slot clock bit caught from the strap while reset is held
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      slot_clk_r <= slot_clock_strap;                           // [RULE5]
    else if (dflt_load)
      slot_clk_r <= dflt_slot_clk;                              // [RULE5]
  end

  // ==========================================================
  // slot feature report
  logic [31:0] slot_r;
  logic [31:0] wr_mask;
  logic        slot_hit;
  logic        slot_wr;
  logic        spl_wr;

  // byte lanes expanded to bits, limited to the writable fields
  assign wr_mask  = {{8{cfg_be[3]}}, {8{cfg_be[2]}}, {8{cfg_be[1]}}, {8{cfg_be[0]}}}
                    & SLOT_RW_MASK;                             // [RULE14]
  assign slot_hit = (cfg_addr == SLOT_FEATURE_OFS) && !IS_UPSTREAM; // [RULE7]
  assign slot_wr  = cfg_wr && slot_hit;
  assign spl_wr   = slot_wr && (wr_mask != ZERO_WORD);          // [RULE10] [RULE11]

  // stored slot fields, config write to a writable lane beats a same-cycle default load
  always_ff @(posedge ref_clk)
  begin
    if (rst || IS_UPSTREAM)
      slot_r <= SLOT_RST;                                       // [RULE7] [RULE8] [RULE9]
    else if (spl_wr)
      slot_r <= (slot_r & ~wr_mask) | (cfg_wdata & wr_mask);    // [RULE10] [RULE11]
    else if (dflt_load)
      slot_r <= dflt_slot & SLOT_IMPL_MASK;                     // [RULE13] [RULE14]
  end

  // power limit message request, one pulse per accepted write
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      spl_msg_req <= 1'b0;
    else
      spl_msg_req <= spl_wr;                                    // [RULE10] [RULE11]
  end

  // power limit outputs mirror the stored fields
  assign spl_value = slot_r[PWR_VAL_LSB +: PWR_VAL_W];
  assign spl_scale = slot_r[PWR_SCALE_LSB +: PWR_SCALE_W];

  // ==========================================================
  // read path
  logic [31:0] link_word;
  logic [31:0] rd_word;

  // link state dword, low half and top bits read zero
  always_comb
  begin
    link_word                            = ZERO_WORD;           // [RULE14]
    link_word[SPEED_LSB +: SPEED_W]      = speed_r;             // [RULE1]
    link_word[WIDTH_LSB +: WIDTH_W]      = width_r;             // [RULE2]
    link_word[TRAIN_ERR_BIT]             = train_err_r;         // [RULE3]
    link_word[TRAINING_BIT]              = training_r;          // [RULE4]
    link_word[SLOT_CLK_BIT]              = slot_clk_r;          // [RULE5]
    link_word[DL_ACTIVE_BIT]             = dl_act_r;            // [RULE6]
  end

  // address decode, unmapped and upstream slot reads give zero
  always_comb
  begin
    rd_word = ZERO_WORD;
    if (cfg_addr == LINK_STATE_OFS)
      rd_word = link_word & LINK_IMPL_MASK;                     // [RULE14]
    else if (slot_hit)
      rd_word = slot_r & SLOT_IMPL_MASK;                        // [RULE7] [RULE12]
  end

  // read answer registered one cycle after the strobe
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      cfg_rdata  <= ZERO_WORD;
      cfg_rvalid <= 1'b0;
    end
    else
    begin
      cfg_rvalid <= cfg_rd;
      if (cfg_rd)
        cfg_rdata <= rd_word;
    end
  end

  // ==========================================================
  // checks
  speed_reset_a : assert property (@(posedge ref_clk) disable iff (rst) // [RULE1]
    $past(rst) |-> speed_r == SPEED_RST)
    else $error("speed field wrong after reset");

  width_reset_a : assert property (@(posedge ref_clk) disable iff (rst) // [RULE2]
    $past(rst) |-> width_r == WIDTH_RST)
    else $error("width field wrong after reset");

  err_set_wins_a : assert property (@(posedge ref_clk) disable iff (rst) // [RULE3]
    train_fail |=> train_err_r ##0 (l0_entered ? 1'b1 : train_err_r))
    else $error("training error not set on failure");

  err_clear_a : assert property (@(posedge ref_clk) disable iff (rst) // [RULE3]
    l0_entered && !train_fail |=> !train_err_r)
    else $error("training error not cleared on L0");

  training_follow_a : assert property (@(posedge ref_clk) disable iff (rst) // [RULE4]
    train_active[*2] |=> training_r && $past(training_r))
    else $error("training indicator not following");

  dl_follow_a : assert property (@(posedge ref_clk) disable iff (rst) // [RULE6]
    ##1 dl_act_r == $past(dl_active))
    else $error("link active bit not following");

  strap_catch_a : assert property (@(posedge ref_clk) disable iff (rst) // [RULE5]
    $past(rst) |-> slot_clk_r == $past(slot_clock_strap))
    else $error("slot clock bit not from strap");

  upstream_slot_a : assert property (@(posedge ref_clk) disable iff (rst) // [RULE7]
    cfg_rd && cfg_addr == SLOT_FEATURE_OFS |=>
      cfg_rdata == (IS_UPSTREAM ? ZERO_WORD : $past(slot_r & SLOT_IMPL_MASK)))
    else $error("slot dword read wrong");

  msg_on_write_a : assert property (@(posedge ref_clk) disable iff (rst) // [RULE10]
    slot_wr && cfg_be[1] |=> spl_msg_req ##1 !spl_msg_req || $past(spl_wr))
    else $error("no limit message after write");

  limit_store_a : assert property (@(posedge ref_clk) disable iff (rst) // [RULE11]
    slot_wr && cfg_be[2] |=> spl_scale[1] == $past(cfg_wdata[PWR_SCALE_LSB + 1]))
    else $error("limit scale not stored");

  reserved_zero_a : assert property (@(posedge ref_clk) disable iff (rst) // [RULE14]
    cfg_rvalid |-> (cfg_rdata & ~(LINK_IMPL_MASK | SLOT_IMPL_MASK)) == ZERO_WORD
      && (!$past(cfg_addr == LINK_STATE_OFS) || cfg_rdata[15:0] == 16'h0000))
    else $error("reserved bits read nonzero");

  load_slot_a : assert property (@(posedge ref_clk) disable iff (rst) // [RULE13]
    dflt_load && !spl_wr && !IS_UPSTREAM |=> slot_r == ($past(dflt_slot) & SLOT_IMPL_MASK))
    else $error("slot defaults not loaded");

  // ==========================================================
  // checks on the stored link fields
  speed_take_a : assert property (@(posedge ref_clk) disable iff (rst) // [RULE1]
    l0_entered |=> speed_r == $past(neg_speed))
    else $error("speed not taken on L0");

  speed_hold_a : assert property (@(posedge ref_clk) disable iff (rst) // [RULE1]
    !l0_entered |=> $stable(speed_r))
    else $error("speed changed without L0");

  width_take_a : assert property (@(posedge ref_clk) disable iff (rst) // [RULE2]
    l0_entered |=> width_r == $past(neg_width))
    else $error("width not taken on L0");

  width_hold_a : assert property (@(posedge ref_clk) disable iff (rst) // [RULE2]
    !l0_entered |=> $stable(width_r))
    else $error("width changed without L0");

  err_hold_a : assert property (@(posedge ref_clk) disable iff (rst) // [RULE3]
    !train_fail && !l0_entered |=> $stable(train_err_r))
    else $error("training error changed by itself");

  training_clear_a : assert property (@(posedge ref_clk) disable iff (rst) // [RULE4]
    !train_active |=> !training_r)
    else $error("training indicator not cleared");

  strap_hold_a : assert property (@(posedge ref_clk) disable iff (rst) // [RULE5]
    !dflt_load |=> $stable(slot_clk_r))
    else $error("slot clock bit changed without load");

  // ==========================================================
  // checks on the stored slot fields and the limit message request
  presence_ro_a : assert property (@(posedge ref_clk) disable iff (rst) // [RULE8] [RULE9]
    slot_wr && !dflt_load |=> $stable(slot_r[HP_CAPABLE_BIT:ATTN_BTN_BIT]))
    else $error("presence bits changed by a write");

  slot_num_ro_a : assert property (@(posedge ref_clk) disable iff (rst) // [RULE12]
    slot_wr && !dflt_load |=> $stable(slot_r[SLOT_NUM_LSB +: SLOT_NUM_W]))
    else $error("slot number changed by a write");

  value_store_a : assert property (@(posedge ref_clk) disable iff (rst) // [RULE10]
    slot_wr && cfg_be[1] |=>
      spl_value[PWR_VAL_W-1:1] == $past(cfg_wdata[PWR_VAL_LSB+PWR_VAL_W-1:PWR_VAL_LSB+1]))
    else $error("limit value not stored");

  value_low_a : assert property (@(posedge ref_clk) disable iff (rst) // [RULE10]
    slot_wr && cfg_be[0] |=> spl_value[0] == $past(cfg_wdata[PWR_VAL_LSB]))
    else $error("limit value low bit not stored");

  scale_low_a : assert property (@(posedge ref_clk) disable iff (rst) // [RULE11]
    slot_wr && cfg_be[1] |=> spl_scale[0] == $past(cfg_wdata[PWR_SCALE_LSB]))
    else $error("limit scale low bit not stored");

  no_msg_idle_a : assert property (@(posedge ref_clk) disable iff (rst) // [RULE10] [RULE11]
    !slot_wr |=> !spl_msg_req)
    else $error("limit message without a write");

  // ==========================================================
  // checks on the read path
  rate_read_a : assert property (@(posedge ref_clk) disable iff (rst) // [RULE1] [RULE2]
    cfg_rd && cfg_addr == LINK_STATE_OFS |=>
      cfg_rdata[WIDTH_LSB+WIDTH_W-1:SPEED_LSB] == $past({width_r, speed_r}))
    else $error("speed or width read wrong");

  flag_read_a : assert property (@(posedge ref_clk) disable iff (rst) // [RULE3] [RULE4]
    cfg_rd && cfg_addr == LINK_STATE_OFS |=>
      cfg_rdata[TRAINING_BIT:TRAIN_ERR_BIT] == $past({training_r, train_err_r}))
    else $error("training flags read wrong");

  link_up_read_a : assert property (@(posedge ref_clk) disable iff (rst) // [RULE5] [RULE6]
    cfg_rd && cfg_addr == LINK_STATE_OFS |=>
      cfg_rdata[DL_ACTIVE_BIT:SLOT_CLK_BIT] == $past({dl_act_r, slot_clk_r}))
    else $error("clock or link active bit read wrong");

endmodule : pls_regs

//--- test/pls_link_model.sv
// link partner model: trains the link on request, then fails or reaches L0
// assumes go is a one-cycle pulse and fail_req, spd, wid are held by the bench
`timescale 1ns/1ps
module pls_link_model (
  input  wire logic       ref_clk,      // core clock
  input  wire logic       rst,          // sync reset, high
  input  wire logic       go,           // start training
  input  wire logic       fail_req,     // end in failure
  input  wire logic [3:0] spd,          // rate to report
  input  wire logic [5:0] wid,          // lanes to report
  output logic      [3:0] neg_speed,    // rate code
  output logic      [5:0] neg_width,    // lane count
  output logic            train_fail,   // failure pulse
  output logic            train_active, // training level
  output logic            l0_entered,   // L0 pulse
  output logic            dl_active     // link layer up
);
  logic [2:0] cnt_r;
  // =====================================
  // training sequence; rate and width are junk outside the L0 or failure pulse
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      {cnt_r, train_fail, train_active, l0_entered, dl_active} <= '0;
    end
    else
    begin
      train_fail <= (cnt_r == 3'h1) && fail_req;
      l0_entered <= (cnt_r == 3'h1) && !fail_req;
      neg_speed  <= (cnt_r == 3'h1) ? spd : ~spd;
      neg_width  <= (cnt_r == 3'h1) ? wid : ~wid;
      if (go)
      begin
        {cnt_r, train_active, dl_active} <= {3'h4, 1'b1, 1'b0};
      end
      else if (cnt_r != 3'h0)
      begin
        cnt_r <= cnt_r - 3'h1;
        if (cnt_r == 3'h1)
          {train_active, dl_active} <= {1'b0, !fail_req};
      end
    end
  end
endmodule : pls_link_model

//--- test/tb_top.sv
// bench for the link state and slot feature registers, downstream port
// assumes the partner model drives the status inputs
`timescale 1ns/1ps
module tb_top;
  import pls_pkg::*;
  logic        ref_clk, rst, cfg_rd, cfg_wr, strap, dld, dld_clk, go, fail_req;
  logic        rvalid, msg, tf, ta, l0, dla, e_err, e_trn, e_clk, e_dla;
  logic [7:0]  cfg_addr, sval;
  logic [3:0]  cfg_be, spd, nspd, e_spd;
  logic [31:0] cfg_wdata, rdata, dslot, e_slot, d, m;
  logic [5:0]  wid, nwid, e_wid;
  logic [1:0]  sscl;
  int          fails, tests_run;
  pls_regs u_pls_regs (.ref_clk(ref_clk), .rst(rst), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr),
    .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(rdata),
    .cfg_rvalid(rvalid), .neg_speed(nspd), .neg_width(nwid), .train_fail(tf),
    .train_active(ta), .l0_entered(l0), .dl_active(dla), .slot_clock_strap(strap),
    .dflt_load(dld), .dflt_slot(dslot), .dflt_slot_clk(dld_clk), .spl_msg_req(msg),
    .spl_value(sval), .spl_scale(sscl));
  pls_link_model u_pls_link_model (.ref_clk(ref_clk), .rst(rst), .go(go),
    .fail_req(fail_req), .spd(spd), .wid(wid), .neg_speed(nspd), .neg_width(nwid),
    .train_fail(tf), .train_active(ta), .l0_entered(l0), .dl_active(dla));
  // =====================================
  // clock and watchdog
  initial
  begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    fails++;
    test_done();
  end
  // expected link dword
  function automatic logic [31:0] link_exp();
    return {2'b00, e_dla, e_clk, e_trn, e_err, e_wid, e_spd, 16'h0000};
  endfunction : link_exp
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      fails++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  // one read, answer checked one cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    {cfg_rd, cfg_addr} = {1'b1, a};
    @(negedge ref_clk);
    cfg_rd = 1'b0;
    chk("rvalid", 32'h1, 32'(rvalid));
    chk($sformatf("read %h", a), e, rdata);
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] dt);
    {cfg_wr, cfg_addr, cfg_be, cfg_wdata} = {1'b1, a, be, dt};
    @(negedge ref_clk);
    cfg_wr = 1'b0;
  endtask : wr
  // one training run, link dword checked mid-way and at the end
  task automatic train(input logic f);
    {fail_req, spd, go} = {f, 4'($urandom_range(2, 1)), 1'b1};
    wid = 6'(1 << $urandom_range(2, 0));
    @(negedge ref_clk);
    go = 1'b0;
    repeat (2) @(negedge ref_clk);
    {e_trn, e_dla} = 2'b10;
    rd(LINK_STATE_OFS, link_exp());
    repeat (6) @(negedge ref_clk);
    {e_trn, e_err} = {1'b0, f};
    if (!f)
      {e_spd, e_wid, e_dla} = {spd, wid, 1'b1};
    rd(LINK_STATE_OFS, link_exp());
  endtask : train
  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : test_done
  // =====================================
  // main sequence
  initial
  begin
    {rst, cfg_rd, cfg_wr, cfg_addr, cfg_be, cfg_wdata} = {1'b1, 46'h0};
    {strap, dld, dld_clk, dslot, go, fail_req, spd, wid} = {1'b1, 46'h0};
    {fails, tests_run} = 0;
    void'($urandom(32'ha3db4f1f));
    repeat (12) @(negedge ref_clk);
    {rst, strap} = 2'b00;
    {e_spd, e_wid, e_err, e_trn, e_clk, e_dla} = {SPEED_RST, WIDTH_RST_DN, 4'b0010};
    rd(LINK_STATE_OFS, link_exp());
    rd(SLOT_FEATURE_OFS, SLOT_RST);
    train(1'b1);
    train(1'b0);
    train(1'b1);
    train(1'b0);
    // management load of new defaults sends no message
    {dslot, dld_clk, dld} = {$urandom, 2'b01};
    @(negedge ref_clk);
    dld = 1'b0;
    {e_slot, e_clk} = {dslot & SLOT_IMPL_MASK, 1'b0};
    chk("load msg", 32'h0, 32'(msg));
    rd(SLOT_FEATURE_OFS, e_slot);
    rd(LINK_STATE_OFS, link_exp());
    // slot writes: all lanes, top lane only, all ones, then random lanes
    for (int i = 0; i < 8; i++)
    begin
      cfg_be = (i == 0 || i == 2) ? 4'hf : (i == 1) ? 4'h8 : 4'($urandom);
      d = (i == 2) ? 32'hffffffff : $urandom;
      m = {{8{cfg_be[3]}}, {8{cfg_be[2]}}, {8{cfg_be[1]}}, {8{cfg_be[0]}}} & SLOT_RW_MASK;
      e_slot = (e_slot & ~m) | (d & m);
      wr(SLOT_FEATURE_OFS, cfg_be, d);
      chk("msg", 32'(|cfg_be[2:0]), 32'(msg));
      chk("value", 32'(e_slot[14:7]), 32'(sval));
      chk("scale", 32'(e_slot[16:15]), 32'(sscl));
      rd(SLOT_FEATURE_OFS, e_slot);
    end
    // read-only and unmapped places
    wr(LINK_STATE_OFS, 4'hf, 32'hffffffff);
    rd(LINK_STATE_OFS, link_exp());
    wr(8'h10, 4'hf, 32'hffffffff);
    chk("stray msg", 32'h0, 32'(msg));
    rd(8'h10, ZERO_WORD);
    // mid-run reset: strap caught again, trained fields back to reset values
    e_clk = 1'($urandom);
    {rst, strap} = {1'b1, e_clk};
    repeat (3) @(negedge ref_clk);
    {rst, strap} = {1'b0, ~e_clk};
    {e_spd, e_wid, e_err, e_trn, e_dla} = {SPEED_RST, WIDTH_RST_DN, 3'b000};
    rd(LINK_STATE_OFS, link_exp());
    rd(SLOT_FEATURE_OFS, SLOT_RST);
    test_done();
  end
endmodule : tb_top
